/* File: logic/charge_count_interrupt.sv */
// charge unit flag, direction latch and clear logic
//
// Operation
// - flag goes low per charge unit, latched
// - direction latched with flag assertion
// - further units while latched are lost
// - clear low 20us releases flag and latch
// - counting continues regardless of latches
// - after clear, direction follows live current
// - direction released high charging, low discharging
// - direction change shows after two reversals
// - flag tied to clear self-clears
// - self-clear keeps flag low 1us minimum
// - 1024-step up/down counter forms units
// - shutdown resets and releases both outputs
// - wait 5ms before counting after reset
`timescale 1ns/100ps
module charge_count_interrupt #(
  parameter int unsigned INIT_CYCLES = charge_count_pkg::INIT_CYC
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic power_down_n,
  input wire logic reversal_strobe,
  input wire logic reversal_dir,
  input wire logic flag_clear_n,
  output logic charge_flag_n_o,
  output logic charge_flag_n_oe,
  output logic current_direction_out_o,
  output logic current_direction_out_oe
);
  localparam int unsigned CLR_CYC = charge_count_pkg::CLR_MIN_CYC;
  localparam int unsigned FLAG_CYC = charge_count_pkg::FLAG_MIN_CYC;

  typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_INIT = 2'b01,
    ST_RUN = 2'b11
  } phase_e;

  logic pd_meta_q, pd_sync_q, clr_meta_q, clr_sync_q;
  phase_e phase_q, phase_d;
  logic [22:0] init_q, init_d;
  logic [8:0] clr_cnt_q, clr_cnt_d;
  logic [8:0] low_cnt_q, low_cnt_d;
  logic flag_q, flag_d, pol_q, pol_d;
  logic run;

  unit_event_if ev ();

  // true once a saturating width count has reached its limit
  function automatic logic reached(input logic [8:0] cnt, input int unsigned lim);
    reached = 32'(cnt) >= lim;
  endfunction : reached

  // pin synchronisers
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      pd_meta_q <= 1'b0;
      pd_sync_q <= 1'b0;
      clr_meta_q <= 1'b1;
      clr_sync_q <= 1'b1;
    end
    else
    begin
      pd_meta_q <= power_down_n;
      pd_sync_q <= pd_meta_q;
      clr_meta_q <= flag_clear_n;
      clr_sync_q <= clr_meta_q;
    end
  end

  assign run = (phase_q == ST_RUN);

  // counter runs apart from the latches
  reversal_counter #(.STEPS(charge_count_pkg::UNIT_STEPS)) u_counter (
    .core_clk(core_clk),
    .run(run),
    .reversal(reversal_strobe),
    .charge_dir(reversal_dir),
    .ev(ev)
  );

  // power phase: off, initialization wait, counting
  always_comb
  begin
    phase_d = phase_q;
    init_d = init_q;
    case (phase_q)
      ST_OFF:
      begin
        init_d = '0;
        if (pd_sync_q)
          phase_d = ST_INIT;
      end
      ST_INIT:
      begin
        init_d = init_q + 1'b1;
        if (32'(init_q) >= INIT_CYCLES - 1)
          phase_d = ST_RUN;
      end
      ST_RUN:
        phase_d = ST_RUN;
      default:
        phase_d = ST_OFF;
    endcase
    if (!pd_sync_q)
      phase_d = ST_OFF;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      phase_q <= ST_OFF;
      init_q <= '0;
    end
    else
    begin
      phase_q <= phase_d;
      init_q <= init_d;
    end
  end

  // flag and direction latches with clear width qualification
  always_comb
  begin
    flag_d = flag_q;
    pol_d = pol_q;
    clr_cnt_d = clr_sync_q ? '0 : clr_cnt_q;
    low_cnt_d = low_cnt_q;
    if (!clr_sync_q && !reached(clr_cnt_q, CLR_CYC))
      clr_cnt_d = clr_cnt_q + 1'b1;
    if (flag_q && !reached(low_cnt_q, FLAG_CYC))
      low_cnt_d = low_cnt_q + 1'b1;
    // clear only after the full width and the minimum low time;
    // a flag tied to the clear pin takes this same path, so it
    // releases itself once its own low level has met the width
    if (flag_q && reached(clr_cnt_q, CLR_CYC) && reached(low_cnt_q, FLAG_CYC))
    begin
      flag_d = 1'b0;
      low_cnt_d = '0;
    end
    if (!flag_q)
      pol_d = ev.live_charge;
    if (ev.unit_pulse && !flag_q)
    begin
      flag_d = 1'b1;
      pol_d = ev.unit_charge;
      low_cnt_d = '0;
    end
    // units arriving while latched are dropped
    if (!run)
    begin
      flag_d = 1'b0;
      pol_d = 1'b1;
      low_cnt_d = '0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      flag_q <= 1'b0;
      pol_q <= 1'b1;
      clr_cnt_q <= '0;
      low_cnt_q <= '0;
    end
    else
    begin
      flag_q <= flag_d;
      pol_q <= pol_d;
      clr_cnt_q <= clr_cnt_d;
      low_cnt_q <= low_cnt_d;
    end
  end

  // open-drain outputs; low driven only
  assign charge_flag_n_o = 1'b0;
  // released at once when counting stops, not a cycle later
  assign charge_flag_n_oe = flag_q && run;
  assign current_direction_out_o = 1'b0;
  assign current_direction_out_oe = run && !pol_q;

  a_power_down_n_release: assert property (@(posedge core_clk) disable iff (!rst_n)
    !pd_sync_q |=> !charge_flag_n_oe && !current_direction_out_oe)
    else $error("outputs driven in shutdown");
  a_flag_sets: assert property (@(posedge core_clk) disable iff (!rst_n)
    (ev.unit_pulse && !flag_q && run) |=> flag_q)
    else $error("unit did not set flag");
  a_pol_latch: assert property (@(posedge core_clk) disable iff (!rst_n)
    (ev.unit_pulse && !flag_q && run) |=> pol_q == $past(ev.unit_charge))
    else $error("direction not latched");
  a_pol_held: assert property (@(posedge core_clk) disable iff (!rst_n)
    (flag_q && $past(flag_q) && run) |-> $stable(pol_q))
    else $error("direction moved while latched");
  a_clear_width: assert property (@(posedge core_clk) disable iff (!rst_n)
    ($fell(flag_q) && run) |-> 32'($past(clr_cnt_q)) >= CLR_CYC
      && 32'($past(low_cnt_q)) >= FLAG_CYC)
    else $error("flag cleared too early");
  a_self_low: assert property (@(posedge core_clk) disable iff (!rst_n)
    ($rose(flag_q)) |-> (flag_q || !run) [*8] ##1 (flag_q || !run) ##1 (flag_q || !run))
    else $error("flag pulse too short");
  a_flag_holds: assert property (@(posedge core_clk) disable iff (!rst_n)
    (flag_q && run && clr_sync_q && $past(clr_sync_q)) |=> flag_q)
    else $error("flag released without clear");
  a_unit_lost: assert property (@(posedge core_clk) disable iff (!rst_n)
    (ev.unit_pulse && flag_q && run && clr_sync_q && $past(clr_sync_q)) |=> flag_q && $stable(pol_q))
    else $error("latched unit disturbed");
  a_outputs_off: assert property (@(posedge core_clk) disable iff (!rst_n)
    !run |-> !charge_flag_n_oe && !current_direction_out_oe)
    else $error("outputs driven while not counting");
  a_live_pol: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!flag_q && $past(!flag_q) && run && $past(run)) |-> pol_q == $past(ev.live_charge))
    else $error("direction not following");
  a_init_wait: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(run) |-> 32'($past(init_q)) >= INIT_CYCLES - 1)
    else $error("counting before init wait");
endmodule : charge_count_interrupt

/* File: logic/charge_count_pkg.sv */
// constants shared by the charge count interrupt logic
package charge_count_pkg;
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned CLK_NS = 1_000_000_000 / CLK_HZ;
  // minimum clear low width
  localparam int unsigned CLR_MIN_NS = 20_000;
  localparam int unsigned CLR_MIN_CYC = (CLR_MIN_NS + CLK_NS - 1) / CLK_NS;
  // minimum flag low pulse in self-clearing use
  localparam int unsigned FLAG_MIN_NS = 1_000;
  localparam int unsigned FLAG_MIN_CYC = (FLAG_MIN_NS + CLK_NS - 1) / CLK_NS;
  // initialization interval after reset or shutdown
  localparam int unsigned INIT_MS = 5;
  localparam int unsigned INIT_CYC = INIT_MS * (CLK_HZ / 1000);
  // reversal counter length and direction filter length
  localparam int unsigned UNIT_STEPS = 1024;
  localparam int unsigned DIR_REVERSALS = 2;
  localparam int unsigned CNT_W = 10;
  localparam logic [CNT_W-1:0] CNT_MID = 10'h200;
  localparam logic [CNT_W-1:0] CNT_MAX = 10'h3ff;
  localparam logic [CNT_W-1:0] CNT_MIN = 10'h000;
  localparam int unsigned DIR_W = 2;
endpackage : charge_count_pkg

/* File: logic/reversal_counter.sv */
// reversal up/down counter forming charge unit events
`timescale 1ns/100ps
module reversal_counter #(
  parameter int unsigned STEPS = charge_count_pkg::UNIT_STEPS
) (
  input wire logic core_clk,
  input wire logic run,
  input wire logic reversal,
  input wire logic charge_dir,
  unit_event_if.source ev
);
  // top of the count follows the unit length
  localparam logic [charge_count_pkg::CNT_W-1:0] TOP = charge_count_pkg::CNT_W'(STEPS - 1);

  logic [charge_count_pkg::CNT_W-1:0] cnt_q, cnt_d;
  logic [charge_count_pkg::DIR_W-1:0] same_q, same_d;
  logic dir_q, dir_d, live_q, live_d, pulse_q, pulse_d, uchg_q, uchg_d;

  // count each reversal; wrap ends form one unit
  always_comb
  begin
    cnt_d = cnt_q;
    same_d = same_q;
    dir_d = dir_q;
    live_d = live_q;
    pulse_d = 1'b0;
    uchg_d = uchg_q;
    if (!run)
    begin
      cnt_d = charge_count_pkg::CNT_MID;
      same_d = '0;
      dir_d = 1'b1;
      live_d = 1'b1;
      uchg_d = 1'b1;
    end
    else if (reversal)
    begin
      if (charge_dir)
      begin
        cnt_d = cnt_q + 1'b1;
        if (cnt_q == TOP)
        begin
          pulse_d = 1'b1;
          uchg_d = 1'b1;
        end
      end
      else
      begin
        cnt_d = cnt_q - 1'b1;
        if (cnt_q == charge_count_pkg::CNT_MIN)
        begin
          pulse_d = 1'b1;
          uchg_d = 1'b0;
        end
      end
      // new direction shows only after two reversals in it
      if (charge_dir == dir_q)
        same_d = '0;
      else if (same_q == charge_count_pkg::DIR_W'(charge_count_pkg::DIR_REVERSALS - 1))
      begin
        dir_d = charge_dir;
        same_d = '0;
      end
      else
        same_d = same_q + 1'b1;
      live_d = dir_d;
    end
  end

  // counter registers
  always_ff @(posedge core_clk)
  begin
    cnt_q <= cnt_d;
    same_q <= same_d;
    dir_q <= dir_d;
    live_q <= live_d;
    pulse_q <= pulse_d;
    uchg_q <= uchg_d;
  end

  assign ev.unit_pulse = pulse_q;
  assign ev.unit_charge = uchg_q;
  assign ev.live_charge = live_q;
endmodule : reversal_counter

/* File: logic/unit_event_if.sv */
// charge unit event carrier between counter and latch logic
`timescale 1ns/100ps
interface unit_event_if;
  logic unit_pulse;
  logic unit_charge;
  logic live_charge;
  modport source (output unit_pulse, output unit_charge, output live_charge);
  modport sink (input unit_pulse, input unit_charge, input live_charge);
endinterface : unit_event_if

/* File: tb/charge_count_interrupt_tb.sv */
// self-checking bench for the charge count interrupt logic
`timescale 1ns/100ps
module charge_count_interrupt_tb;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic power_down_n = 1'b1;
  logic reversal_strobe = 1'b0;
  logic reversal_dir = 1'b1;
  logic self_tie = 1'b0;
  logic flag_clear_n, flag_o, flag_oe, dir_o, dir_oe, flag_pin, dir_pin;
  int bad_count = 0;
  int total_checks = 0;
  int w;
  // open-drain pins with pull-ups
  assign flag_pin = flag_oe ? flag_o : 1'b1;
  assign dir_pin = dir_oe ? dir_o : 1'b1;
  initial forever #50 core_clk = ~core_clk;
  charge_count_interrupt #(.INIT_CYCLES(20)) i_dut (.core_clk(core_clk), .rst_n(rst_n),
    .power_down_n(power_down_n), .reversal_strobe(reversal_strobe), .reversal_dir(reversal_dir),
    .flag_clear_n(flag_clear_n), .charge_flag_n_o(flag_o), .charge_flag_n_oe(flag_oe),
    .current_direction_out_o(dir_o), .current_direction_out_oe(dir_oe));
  host_model i_host (.core_clk(core_clk), .flag_pin(flag_pin), .dir_pin(dir_pin),
    .self_tie(self_tie), .battery_ok(power_down_n), .flag_clear_n(flag_clear_n));
  task chk(input string name, input logic exp, input logic got);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR %s expected %b seen %b", name, exp, got);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc
  // n one-cycle reversal strobes in direction d, then settle
  task rev(input int n, input logic d);
    repeat (n)
    begin
      @(posedge core_clk);
      reversal_strobe <= 1'b1;
      reversal_dir <= d;
      @(posedge core_clk);
      reversal_strobe <= 1'b0;
    end
    cyc(3);
  endtask : rev
  task finish_test;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : finish_test
  // reset release, idle outputs, initialization wait
  task t_reset_idle;
    cyc(10);
    rst_n <= 1'b1;
    cyc(2);
    chk("flag idle", 1'b1, flag_pin);
    chk("dir idle", 1'b1, dir_pin);
    cyc(30);
  endtask : t_reset_idle
  // first unit from mid-scale, latch holds through reversals
  task t_first_unit;
    rev(511, 1'b1);
    chk("flag early", 1'b1, flag_pin);
    rev(1, 1'b1);
    chk("flag unit", 1'b0, flag_pin);
    chk("dir charge", 1'b1, dir_pin);
    rev(512, 1'b1);
    rev(3, 1'b0);
    chk("flag held", 1'b0, flag_pin);
    chk("dir latched", 1'b1, dir_pin);
  endtask : t_first_unit
  // a clear just short of the width, then a full one
  task t_clear_width;
    i_host.pulse_clear(charge_count_pkg::CLR_MIN_CYC - 5);
    cyc(5);
    chk("short clear", 1'b0, flag_pin);
    i_host.pulse_clear(charge_count_pkg::CLR_MIN_CYC + 5);
    cyc(5);
    chk("flag cleared", 1'b1, flag_pin);
    chk("dir live", 1'b0, dir_pin);
  endtask : t_clear_width
  // direction filter and counting kept across the latch
  task t_live_dir;
    rev(1, 1'b1);
    chk("dir one rev", 1'b0, dir_pin);
    rev(1, 1'b1);
    chk("dir two rev", 1'b1, dir_pin);
    rev(511, 1'b1);
    chk("flag kept count", 1'b1, flag_pin);
    rev(2, 1'b1);
    chk("flag next unit", 1'b0, flag_pin);
  endtask : t_live_dir
  // a whole unit while latched is lost
  task t_lost_unit;
    rev(1024, 1'b1);
    chk("flag lost unit", 1'b0, flag_pin);
    i_host.pulse_clear(charge_count_pkg::CLR_MIN_CYC + 5);
    cyc(5);
    chk("flag lost cleared", 1'b1, flag_pin);
  endtask : t_lost_unit
  // flag tied to clear releases itself, bounded wait
  task t_self_clear;
    self_tie <= 1'b1;
    rev(1, 1'b0);
    chk("flag under", 1'b0, flag_pin);
    chk("dir discharge", 1'b0, dir_pin);
    w = 3;
    while (flag_pin === 1'b0 && w < 1000)
    begin
      cyc(1);
      w++;
    end
    chk("self clear", 1'b1, w >= charge_count_pkg::FLAG_MIN_CYC && w < 1000);
    if (w >= 1000) finish_test();
    chk("charge units", 1'b1, i_host.chg_units == 2);
    chk("discharge units", 1'b1, i_host.dis_units == 1);
    self_tie <= 1'b0;
  endtask : t_self_clear
  // shutdown releases outputs; counting waits out the init interval
  task t_shutdown;
    rev(2, 1'b0);
    chk("dir discharge live", 1'b0, dir_pin);
    power_down_n <= 1'b0;
    cyc(5);
    chk("dir shutdown", 1'b1, dir_pin);
    chk("flag shutdown", 1'b1, flag_pin);
    power_down_n <= 1'b1;
    rev(521, 1'b1);
    chk("flag init", 1'b1, flag_pin);
    rev(2, 1'b1);
    chk("flag after init", 1'b0, flag_pin);
  endtask : t_shutdown
  // main sequence
  initial
  begin
    t_reset_idle();
    t_first_unit();
    t_clear_width();
    t_live_dir();
    t_lost_unit();
    t_self_clear();
    t_shutdown();
    finish_test();
  end
endmodule : charge_count_interrupt_tb

/* File: tb/host_model.sv */
// host microcontroller model servicing charge interrupts
`timescale 1ns/100ps
module host_model (
  input wire logic core_clk,
  input wire logic flag_pin,
  input wire logic dir_pin,
  input wire logic self_tie,
  input wire logic battery_ok,
  output logic flag_clear_n
);
  logic hold_n = 1'b1;
  logic flag_q = 1'b1;
  int chg_units = 0;
  int dis_units = 0;
  // clear comes from the host pulse or from the flag pin itself
  assign flag_clear_n = self_tie ? flag_pin : hold_n;
  // split flag assertions by the latched direction
  always @(posedge core_clk)
  begin
    if (battery_ok && flag_q && !flag_pin)
    begin
      if (dir_pin) chg_units++;
      else dis_units++;
    end
    flag_q <= flag_pin;
  end
  // clear low for n cycles, well inside the service time
  task pulse_clear(input int n);
    @(posedge core_clk);
    hold_n <= 1'b0;
    repeat (n) @(posedge core_clk);
    hold_n <= 1'b1;
  endtask : pulse_clear
endmodule : host_model
